// File: common/acq_seq_pkg.sv
// constants and types for the acquisition trigger sequencer
`default_nettype none
package acq_seq_pkg;
    // widths of settings and data
    localparam int CNT_W = 24;
    localparam int ARM_W = 8;
    localparam int ADDR_W = 19;
    localparam int SEG_W = 7;
    localparam int DATA_W = 16;
    localparam int SHIFT_W = 3;
    // memory geometry
    localparam logic [CNT_W-1:0] MEM_DEPTH = 24'h080000;
    localparam logic [CNT_W-1:0] STREAM_MAX = 24'hffffff;
    localparam logic [CNT_W-1:0] NV_RESERVE = 24'h000004;
    localparam logic [SHIFT_W-1:0] MAX_SHIFT = 3'h7;
    // partition thresholds
    localparam logic [ARM_W-1:0] PART_ARM_MIN = 8'h01;
    localparam logic signed [CNT_W-1:0] PART_OFFSET_MAX = -24'sd3;
    localparam logic [CNT_W-1:0] PART_POINTS_MIN = 24'h000009;
    // reset values of settings
    localparam logic [CNT_W-1:0] RST_POINTS = 24'h000001;
    localparam logic [ARM_W-1:0] RST_ARMS = 8'h01;
    localparam logic [CNT_W-1:0] RST_OFFSET = 24'h000000;
    // switch-over window between bursts
    localparam int CLK_PERIOD_NS = 4;
    localparam int SWITCH_TIME_NS = 630000;
    localparam int SWITCH_CYCLES = SWITCH_TIME_NS / CLK_PERIOD_NS;
    localparam int SW_W = 18;
    // reading destinations
    typedef enum logic [1:0]
    {
        DEST_MEMORY,
        DEST_SYSTEM_BUS,
        DEST_LOCAL_BUS
    } dest_e;
    // sequencer states
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_INITIATED,
        ST_SWITCH,
        ST_WAIT_ARM,
        ST_WAIT_TRIG
    } seq_state_e;
endpackage
`default_nettype wire

// File: hdl/acquisition_trigger_sequencer.sv
// idle/initiated/arm/trigger sequencer with segmented reading memory
`default_nettype none
module acquisition_trigger_sequencer #(
    parameter int SWITCH_CYCLES = acq_seq_pkg::SWITCH_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic init_cmd,
    input wire logic abort_cmd,
    input wire logic imm_trigger_cmd,
    input wire logic arm_pin,
    input wire logic trigger_pin,
    input wire logic reading_count_wr,
    input wire logic sweep_point_total_wr,
    input wire logic pre_arm_offset_wr,
    input wire logic arm_count_wr,
    input wire logic [acq_seq_pkg::CNT_W-1:0] setting_value,
    input wire logic [acq_seq_pkg::ARM_W-1:0] arm_count_value,
    input wire logic nv_mode,
    input wire logic [1:0] dest_sel,
    input wire logic [acq_seq_pkg::DATA_W-1:0] sample_data,
    output logic [acq_seq_pkg::CNT_W-1:0] sweep_point_total,
    output logic [acq_seq_pkg::CNT_W-1:0] pre_arm_offset,
    output logic [acq_seq_pkg::ARM_W-1:0] arm_count,
    output logic busy,
    output logic waiting_arm,
    output logic segment_ready,
    output logic partitioned,
    output logic [acq_seq_pkg::ARM_W:0] segment_count,
    output logic [acq_seq_pkg::CNT_W-1:0] reading_limit,
    output logic limit_exceeded,
    output logic trigger_ignored_err,
    output logic done,
    output logic mem_we,
    output logic [acq_seq_pkg::ADDR_W-1:0] mem_addr,
    output logic [acq_seq_pkg::DATA_W-1:0] mem_wdata,
    output logic stream_valid,
    output logic [acq_seq_pkg::DATA_W-1:0] stream_data
);
    localparam logic [acq_seq_pkg::SW_W-1:0] SW_LOAD =
        acq_seq_pkg::SW_W'(SWITCH_CYCLES - 1);

    typedef struct packed {
        acq_seq_pkg::seq_state_e state;
        logic [2:0] arm_sync;
        logic [2:0] trig_sync;
        logic [acq_seq_pkg::CNT_W-1:0] points;
        logic [acq_seq_pkg::CNT_W-1:0] offset;
        logic [acq_seq_pkg::ARM_W-1:0] arms;
        logic [acq_seq_pkg::ARM_W-1:0] arms_done;
        logic [acq_seq_pkg::SEG_W-1:0] seg_idx;
        logic [acq_seq_pkg::CNT_W-1:0] readings;
        logic [acq_seq_pkg::CNT_W-1:0] wr_off;
        logic [acq_seq_pkg::ADDR_W-1:0] lin_base;
        logic [acq_seq_pkg::SW_W-1:0] sw_count;
        logic err;
        logic done;
        logic we;
        logic [acq_seq_pkg::ADDR_W-1:0] addr;
        logic [acq_seq_pkg::DATA_W-1:0] wdata;
        logic svalid;
        logic [acq_seq_pkg::DATA_W-1:0] sdata;
    } seq_s;

    seq_s cur;
    seq_s nxt;

    // log2 of the segment count: arm count rounded up, capped at 128
    function automatic logic [acq_seq_pkg::SHIFT_W-1:0] seg_shift(
        input logic [acq_seq_pkg::ARM_W-1:0] a
    );
        logic [acq_seq_pkg::SHIFT_W-1:0] s;
        s = '0;
        for (int i = 1; i <= int'(acq_seq_pkg::MAX_SHIFT); i++)
        begin
            if ({1'b0, a} > ((acq_seq_pkg::ARM_W+1)'(1) << (i - 1)))
            begin
                s = acq_seq_pkg::SHIFT_W'(i);
            end
        end
        return s;
    endfunction

    logic part;
    logic mem_dest;
    logic [acq_seq_pkg::SHIFT_W-1:0] shift;
    logic [acq_seq_pkg::CNT_W-1:0] seg_span;
    logic [acq_seq_pkg::CNT_W-1:0] limit;
    logic [acq_seq_pkg::CNT_W-1:0] pre_count;
    logic [acq_seq_pkg::CNT_W-1:0] post_div;
    logic [acq_seq_pkg::ADDR_W-1:0] seg_base;
    logic [acq_seq_pkg::CNT_W-1:0] reserve;
    logic [acq_seq_pkg::ADDR_W-1:0] burst_base;
    logic arm_evt;
    logic trig_evt;
    logic take;

    // partition decision and segment geometry
    always_comb
    begin
        mem_dest = dest_sel == 2'(acq_seq_pkg::DEST_MEMORY);
        part = cur.arms > acq_seq_pkg::PART_ARM_MIN
            && $signed(cur.offset) <= acq_seq_pkg::PART_OFFSET_MAX
            && cur.points > acq_seq_pkg::PART_POINTS_MIN;
        shift = part ? seg_shift(cur.arms) : '0;
        seg_span = acq_seq_pkg::MEM_DEPTH >> shift;
        post_div = acq_seq_pkg::MEM_DEPTH
            / ((cur.arms == '0) ? 24'h000001
               : {{(acq_seq_pkg::CNT_W-acq_seq_pkg::ARM_W){1'b0}}, cur.arms});
        // recovery words kept per segment in non-volatile mode
        reserve = nv_mode ? acq_seq_pkg::NV_RESERVE : '0;
        if (!mem_dest)
        begin
            limit = acq_seq_pkg::STREAM_MAX;
        end
        else if (part)
        begin
            limit = seg_span - reserve;
        end
        else
        begin
            limit = post_div - reserve;
        end
        // readings owed before an arm can be accepted
        pre_count = $signed(cur.offset) < 0 ? -cur.offset : '0;
        seg_base = acq_seq_pkg::ADDR_W'(
            {{(acq_seq_pkg::CNT_W-acq_seq_pkg::SEG_W){1'b0}}, cur.seg_idx}
            << (acq_seq_pkg::ADDR_W - int'(shift)));
        // unpartitioned bursts sit back to back, none overwritten
        burst_base = part ? seg_base : cur.lin_base;
    end

    // synchronised pin edges, second and third stage only
    assign arm_evt = cur.arm_sync[1] && !cur.arm_sync[2];
    assign trig_evt = cur.trig_sync[1] && !cur.trig_sync[2];

    // next state of the whole sequencer
    always_comb
    begin
        nxt = cur;
        nxt.arm_sync = {cur.arm_sync[1:0], arm_pin};
        nxt.trig_sync = {cur.trig_sync[1:0], trigger_pin};
        nxt.err = 1'b0;
        nxt.done = 1'b0;
        nxt.we = 1'b0;
        nxt.svalid = 1'b0;
        take = 1'b0;
        case (cur.state)
            acq_seq_pkg::ST_IDLE:
            begin
                // settings change only while idle
                if (reading_count_wr || sweep_point_total_wr)
                begin
                    nxt.points = setting_value;
                end
                if (pre_arm_offset_wr)
                begin
                    nxt.offset = setting_value;
                end
                if (arm_count_wr)
                begin
                    nxt.arms = arm_count_value;
                end
                if (imm_trigger_cmd)
                begin
                    nxt.err = 1'b1;
                end
                // begin command leaves idle only when the count fits
                if (init_cmd && !abort_cmd && cur.points <= limit)
                begin
                    nxt.state = acq_seq_pkg::ST_INITIATED;
                    nxt.lin_base = '0;
                    nxt.arms_done = '0;
                    nxt.seg_idx = '0;
                end
            end
            acq_seq_pkg::ST_INITIATED:
            begin
                // each burst restarts its reading count
                nxt.readings = '0;
                nxt.wr_off = '0;
                if (cur.arms_done < cur.arms)
                begin
                    if (part && cur.arms_done != '0)
                    begin
                        nxt.state = acq_seq_pkg::ST_SWITCH;
                        nxt.sw_count = SW_LOAD;
                    end
                    else
                    begin
                        nxt.state = acq_seq_pkg::ST_WAIT_ARM;
                    end
                end
                else
                begin
                    nxt.state = acq_seq_pkg::ST_IDLE;
                    nxt.done = 1'b1;
                end
            end
            acq_seq_pkg::ST_SWITCH:
            begin
                // arm events here are dropped silently
                if (imm_trigger_cmd)
                begin
                    nxt.err = 1'b1;
                end
                if (cur.sw_count == '0)
                begin
                    nxt.state = acq_seq_pkg::ST_WAIT_ARM;
                end
                else
                begin
                    nxt.sw_count = cur.sw_count - 1'b1;
                end
            end
            acq_seq_pkg::ST_WAIT_ARM:
            begin
                if (imm_trigger_cmd)
                begin
                    nxt.err = 1'b1;
                end
                // pre-arm readings fill the circular segment
                if (pre_count != '0 && trig_evt)
                begin
                    take = 1'b1;
                    if (cur.readings < pre_count)
                    begin
                        nxt.readings = cur.readings + 1'b1;
                    end
                end
                if (arm_evt && cur.readings >= pre_count)
                begin
                    nxt.state = acq_seq_pkg::ST_WAIT_TRIG;
                end
            end
            acq_seq_pkg::ST_WAIT_TRIG:
            begin
                // post-arm readings until the count is met
                if (trig_evt || imm_trigger_cmd)
                begin
                    take = 1'b1;
                    nxt.readings = cur.readings + 1'b1;
                    if (cur.readings + 1'b1 >= cur.points)
                    begin
                        nxt.state = acq_seq_pkg::ST_INITIATED;
                        nxt.arms_done = cur.arms_done + 1'b1;
                        nxt.seg_idx = cur.seg_idx + 1'b1;
                        nxt.lin_base = cur.lin_base
                            + acq_seq_pkg::ADDR_W'(cur.points);
                    end
                end
            end
            default:
            begin
                nxt.state = acq_seq_pkg::ST_IDLE;
            end
        endcase
        // reading path: memory write or stream beat
        if (take)
        begin
            if (mem_dest)
            begin
                nxt.we = 1'b1;
                nxt.addr = burst_base + acq_seq_pkg::ADDR_W'(cur.wr_off);
                nxt.wdata = sample_data;
                nxt.wr_off = (cur.wr_off + 1'b1 >= cur.points)
                    ? '0 : cur.wr_off + 1'b1;
            end
            else
            begin
                nxt.svalid = 1'b1;
                nxt.sdata = sample_data;
            end
        end
        if (abort_cmd && cur.state != acq_seq_pkg::ST_IDLE)
        begin
            nxt.state = acq_seq_pkg::ST_IDLE;
        end
    end

    // single state register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cur <= '0;
            cur.state <= acq_seq_pkg::ST_IDLE;
            cur.points <= acq_seq_pkg::RST_POINTS;
            cur.arms <= acq_seq_pkg::RST_ARMS;
            cur.offset <= acq_seq_pkg::RST_OFFSET;
        end
        else
        begin
            cur <= nxt;
        end
    end

    // stored settings
    assign sweep_point_total = cur.points;
    assign pre_arm_offset = cur.offset;
    assign arm_count = cur.arms;

    // sequencer status and geometry
    assign busy = cur.state != acq_seq_pkg::ST_IDLE;
    assign waiting_arm = cur.state == acq_seq_pkg::ST_WAIT_ARM;
    assign segment_ready = cur.state != acq_seq_pkg::ST_SWITCH;
    assign partitioned = part;
    assign segment_count =
        (acq_seq_pkg::ARM_W+1)'(1) << seg_shift(cur.arms);
    assign reading_limit = limit;
    assign limit_exceeded = cur.points > limit;
    assign trigger_ignored_err = cur.err;
    assign done = cur.done;

    // reading path outputs
    assign mem_we = cur.we;
    assign mem_addr = cur.addr;
    assign mem_wdata = cur.wdata;
    assign stream_valid = cur.svalid;
    assign stream_data = cur.sdata;
endmodule
`default_nettype wire

// File: verification/acq_seq_props.sv
// port-level properties of the acquisition trigger sequencer
`default_nettype none
module acq_seq_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic init_cmd,
    input wire logic abort_cmd,
    input wire logic imm_trigger_cmd,
    input wire logic [acq_seq_pkg::CNT_W-1:0] sweep_point_total,
    input wire logic [acq_seq_pkg::CNT_W-1:0] pre_arm_offset,
    input wire logic [acq_seq_pkg::ARM_W-1:0] arm_count,
    input wire logic busy,
    input wire logic waiting_arm,
    input wire logic segment_ready,
    input wire logic partitioned,
    input wire logic [acq_seq_pkg::ARM_W:0] segment_count,
    input wire logic limit_exceeded,
    input wire logic trigger_ignored_err,
    input wire logic mem_we,
    input wire logic stream_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // an accepted begin command and the cycle after it
    sequence s_start;
        !busy && init_cmd && !abort_cmd && !limit_exceeded;
    endsequence
    sequence s_kept;
        busy && !abort_cmd;
    endsequence
    chk_idle_quiet: assert property (
        !busy && !$past(busy) |-> !mem_we && !stream_valid)
        else $error("reading taken while idle");
    chk_init_leaves: assert property (s_start |=> busy)
        else $error("begin command not taken");
    chk_init_arm: assert property (s_start ##1 s_kept |=> waiting_arm)
        else $error("arm wait not entered");
    chk_abort_idle: assert property (busy && abort_cmd |=> !busy)
        else $error("abort did not return to idle");
    chk_imm_refused: assert property (
        imm_trigger_cmd && (!busy || waiting_arm) |=> trigger_ignored_err)
        else $error("refused trigger not flagged");
    chk_err_cause: assert property (
        trigger_ignored_err |-> $past(imm_trigger_cmd))
        else $error("error flag without trigger request");
    chk_gap_quiet: assert property (
        !segment_ready && !$past(segment_ready) |-> busy && !mem_we)
        else $error("write during switch-over");
    chk_part_cond: assert property (partitioned ==
        (arm_count > 8'h01 && $signed(pre_arm_offset) <= -24'sd3
        && sweep_point_total > 24'h000009))
        else $error("partition condition wrong");
    chk_seg_round: assert property (segment_count >= arm_count
        && segment_count < {arm_count, 1'b0}
        && (segment_count & (segment_count - 9'h001)) == 9'h000)
        else $error("segment count not rounded power of two");
    chk_busy_frozen: assert property (
        busy |=> $stable(sweep_point_total))
        else $error("setting changed while busy");
endmodule
bind acquisition_trigger_sequencer acq_seq_props i_acq_seq_props (.*);
`default_nettype wire

// File: verification/event_source.sv
// arm and trigger source model driving the event pins
`default_nettype none
module event_source (
    input wire logic clk,
    input wire logic arm_req,
    input wire logic trig_req,
    output logic arm_pin,
    output logic trigger_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] arm_left = 2'h0;
    logic [1:0] trig_left = 2'h0;
    assign arm_pin = arm_left != 2'h0;
    assign trigger_pin = trig_left != 2'h0;
    // each request becomes a pulse three cycles wide
    always @(posedge clk)
    begin
        arm_left <= arm_req ? 2'h3 : arm_left - {1'b0, arm_left != 2'h0};
        trig_left <= trig_req ? 2'h3 : trig_left - {1'b0, trig_left != 2'h0};
    end
endmodule
`default_nettype wire

// File: verification/tb_acquisition_trigger_sequencer.sv
// self-checking bench for the acquisition trigger sequencer
`default_nettype none
module tb_acquisition_trigger_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] INIT = 7'h40, ABORT = 7'h20, IMM = 7'h10;
    localparam logic [6:0] RCW = 7'h08, SPW = 7'h04, OFW = 7'h02, ACW = 7'h01;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] ctl = 7'h00;
    logic arm_req = 1'b0;
    logic trig_req = 1'b0;
    logic [23:0] value = 24'h000000;
    logic [7:0] arms = 8'h01;
    logic nv_mode = 1'b0;
    logic [1:0] dest_sel = 2'h0;
    logic arm_pin, trigger_pin, busy, waiting_arm, segment_ready, partitioned;
    logic limit_exceeded, trigger_ignored_err, done, mem_we, stream_valid;
    logic [23:0] sweep_point_total, pre_arm_offset, reading_limit;
    logic [7:0] arm_count;
    logic [8:0] segment_count;
    logic [18:0] mem_addr;
    logic [15:0] mem_wdata, stream_data;
    logic saw_gap = 1'b0;
    logic saw_seg1 = 1'b0;
    int miscompares = 0, tests_run = 0, writes = 0, errs = 0, dones = 0, w0;
    event_source i_event_source (.clk(clk), .arm_req(arm_req),
        .trig_req(trig_req), .arm_pin(arm_pin), .trigger_pin(trigger_pin));
    acquisition_trigger_sequencer #(.SWITCH_CYCLES(8))
    i_acquisition_trigger_sequencer (.clk(clk), .rst_n(rst_n),
        .init_cmd(ctl[6]), .abort_cmd(ctl[5]), .imm_trigger_cmd(ctl[4]),
        .arm_pin(arm_pin), .trigger_pin(trigger_pin),
        .reading_count_wr(ctl[3]), .sweep_point_total_wr(ctl[2]),
        .pre_arm_offset_wr(ctl[1]), .arm_count_wr(ctl[0]),
        .setting_value(value), .arm_count_value(arms), .nv_mode(nv_mode),
        .dest_sel(dest_sel), .sample_data(16'h5a5a),
        .sweep_point_total(sweep_point_total), .pre_arm_offset(pre_arm_offset),
        .arm_count(arm_count), .busy(busy), .waiting_arm(waiting_arm),
        .segment_ready(segment_ready), .partitioned(partitioned),
        .segment_count(segment_count), .reading_limit(reading_limit),
        .limit_exceeded(limit_exceeded), .done(done),
        .trigger_ignored_err(trigger_ignored_err), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .stream_valid(stream_valid), .stream_data(stream_data));
    // clock generator
    initial
    begin
        forever #2 clk = ~clk;
    end
    // count readings, errors, completions and window sightings
    always @(posedge clk)
    begin
        writes <= writes + int'(mem_we) + int'(stream_valid);
        errs <= errs + int'(trigger_ignored_err);
        dones <= dones + int'(done);
        if (!segment_ready) saw_gap <= 1'b1;
        if (mem_we && mem_addr[18]) saw_seg1 <= 1'b1;
    end
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle command pulse, settled outputs afterwards
    task automatic cmd(input logic [6:0] v, input logic [23:0] d);
        @(posedge clk);
        ctl <= v;
        value <= d;
        @(posedge clk);
        ctl <= 7'h00;
        #1;
    endtask
    // pin event through the source model, then let it settle
    task automatic fire(input logic is_arm);
        @(posedge clk);
        arm_req <= is_arm;
        trig_req <= !is_arm;
        @(posedge clk);
        arm_req <= 1'b0;
        trig_req <= 1'b0;
        repeat (7) @(posedge clk);
        #1;
    endtask
    task automatic complete_run;
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #40000;
        miscompares++;
        complete_run();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({busy, segment_ready, arm_count}, 10'h101);
        check(sweep_point_total ^ pre_arm_offset, 24'h000001);
        cmd(IMM, 24'h0);
        cmd(RCW, 24'h000003);
        check(sweep_point_total, 24'h000003);
        check(errs, 1);
        cmd(SPW, 24'h080001);
        check(limit_exceeded, 1'b1);
        cmd(INIT, 24'h0);
        check(busy, 1'b0);
        cmd(SPW, 24'h000002);
        cmd(INIT, 24'h0);
        check(busy, 1'b1);
        @(posedge clk);
        #1;
        check(waiting_arm, 1'b1);
        cmd(IMM, 24'h0);
        cmd(SPW, 24'h000005);
        check(sweep_point_total, 24'h000002);
        check(errs, 2);
        fire(1'b1);
        check(waiting_arm, 1'b0);
        cmd(IMM, 24'h0);
        cmd(IMM, 24'h0);
        repeat (3) @(posedge clk);
        #1;
        check(writes, 2);
        check(dones, 1);
        check(mem_wdata, 16'h5a5a);
        check(busy, 1'b0);
        @(posedge clk);
        dest_sel <= 2'h1;
        cmd(INIT, 24'h0);
        fire(1'b1);
        fire(1'b0);
        fire(1'b0);
        check(busy, 1'b0);
        check(writes, 4);
        check(stream_data, 16'h5a5a);
        check(reading_limit, 24'hffffff);
        @(posedge clk);
        dest_sel <= 2'h0;
        cmd(INIT, 24'h0);
        cmd(ABORT, 24'h0);
        check(busy, 1'b0);
        @(posedge clk);
        arms <= 8'h03;
        cmd(ACW, 24'h0);
        check(segment_count, 9'h004);
        check(reading_limit, 24'h02aaaa);
        @(posedge clk);
        arms <= 8'h02;
        cmd(ACW, 24'h0);
        cmd(OFW, 24'hfffffd);
        cmd(SPW, 24'h00000a);
        check(partitioned, 1'b1);
        check(reading_limit, 24'h040000);
        @(posedge clk);
        nv_mode <= 1'b1;
        @(posedge clk);
        #1;
        check(reading_limit, 24'h03fffc);
        @(posedge clk);
        nv_mode <= 1'b0;
        w0 = writes;
        cmd(INIT, 24'h0);
        repeat (60)
        begin
            if (busy)
                fire(waiting_arm && (writes - w0) % 10 >= 3);
        end
        check({busy, saw_gap, saw_seg1}, 3'b011);
        check(writes - w0, 20);
        check(dones, 3);
        complete_run();
    end
endmodule
`default_nettype wire
